// file: bench/lcdb_bias_pin_select_tb.sv
// Self-checking bench of the LCD bias and pin select block
`timescale 1ns/10ps
module lcdb_bias_pin_select_tb
    import lcdb_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic clk32kPin = 1'b0;
    logic intervalStart = 1'b0;
    lcdb_bias_s biasCtrl;
    logic [3:0] comDriver, comOutEn, liveCom, com;
    logic [31:0] segDriver, segOutEn, liveSeg, r, ctrl, segEn, segDir;
    logic act, refEn, fvr, idle, modeB, refOn;
    logic [2:0] ext, cst, code;
    logic [1:0] pA, pB;
    logic [7:0] addrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
    logic [31:0] rstv [6] = '{32'h0F00, 32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h0};
    int n_mismatch = 0;
    int tests_run = 0;

    always #2 clock = ~clock;

    lcdb_bias_pin_select #(.SEG_PINS(32)) DUT (
        .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .clk32kPin(clk32kPin), .intervalStart(intervalStart), .biasCtrl(biasCtrl),
        .comDriver(comDriver), .comOutEn(comOutEn), .segDriver(segDriver),
        .segOutEn(segOutEn)
    );

    lcdb_glass_model #(.SEG_PINS(32)) glass (
        .comDriver(comDriver), .comOutEn(comOutEn), .segDriver(segDriver),
        .segOutEn(segOutEn), .liveCom(liveCom), .liveSeg(liveSeg)
    );

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic pulse_start();
        @(posedge clock);
        intervalStart <= 1'b1;
        @(posedge clock);
        intervalStart <= 1'b0;
        settle();
    endtask

    // One slow-clock period, long enough for synchroniser and timer to land
    task automatic tick32();
        @(posedge clock);
        clk32kPin <= 1'b1;
        repeat (4) @(posedge clock);
        clk32kPin <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
    endtask

    function automatic logic [3:0] exp_com(input logic a, input logic [1:0] mux);
        logic [3:0] e;
        for (int i = 0; i < 4; i++) begin
            e[i] = a && (i <= mux);
        end
        return e;
    endfunction

    // Hangs are cut short here
    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'hBAD6));
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        settle();
        chk("comOutEn", {28'h0, comOutEn}, 32'h0);
        chk("segDriver", segDriver, 32'h0);
        chk("segOutEn", segOutEn, 32'h0);
        chk("biasCtrl", {18'h0, biasCtrl}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(addrs[i], r);
            chk("reset read", r, rstv[i]);
        end
        // Pin function: every mux code, random directions and enables
        for (int i = 0; i < 20; i++) begin
            ctrl = $urandom & 32'h0F7F;
            ctrl[3:2] = 2'(i);
            ctrl[0] = ctrl[0] | (i < 4);
            segEn = $urandom;
            segDir = $urandom;
            wr(ADDR_CTRL, ctrl);
            wr(ADDR_SEG_EN, segEn);
            wr(ADDR_SEG_DIR, segDir);
            wr(ADDR_STATUS, $urandom);
            settle();
            com = exp_com(ctrl[0], ctrl[3:2]);
            chk("comDriver", {28'h0, comDriver}, {28'h0, com});
            chk("comOutEn", {28'h0, comOutEn}, {28'h0, com | ~ctrl[11:8]});
            chk("liveCom", {28'h0, liveCom}, {28'h0, com});
            chk("segDriver", segDriver, segEn);
            chk("segOutEn", segOutEn, segEn | ~segDir);
            chk("liveSeg", liveSeg, segEn);
            rd(ADDR_CTRL, r);
            chk("ctrl read", r, ctrl);
            rd(ADDR_STATUS, r);
            chk("status com", {28'h0, r[6:3]}, {28'h0, com});
        end
        // Bias reference and contrast gating, mode B forced by code 0
        for (int i = 0; i < 24; i++) begin
            {act, refEn, fvr, idle} = (i < 4) ? {i[0], 3'b111} : 4'($urandom);
            {ext, cst, pA, pB} = 10'($urandom);
            code = i[1] ? 3'h0 : 3'h7;
            wr(ADDR_CTRL, {25'h0, cst, 3'h0, act});
            wr(ADDR_REF, {26'h0, ext, idle, fvr, refEn});
            wr(ADDR_LADDER, {24'h0, pA, pB, 1'b0, code});
            settle();
            pulse_start();
            modeB = (code == 3'h0);
            refOn = act & refEn;
            chk("refOn", {31'h0, biasCtrl.refOn}, {31'h0, refOn});
            chk("contrastOn", {31'h0, biasCtrl.contrastOn}, {31'h0, refOn});
            chk("fvrRequest", {31'h0, biasCtrl.fvrRequest}, {31'h0, refOn & fvr});
            chk("fvrBufOn", {31'h0, biasCtrl.fvrBufOn},
                {31'h0, refOn & fvr & ~(idle & modeB)});
            chk("extBias", {29'h0, biasCtrl.extBiasPinEn}, {29'h0, ext});
            chk("ladderPower", {30'h0, biasCtrl.ladderPower},
                {30'h0, act ? (modeB ? pB : pA) : 2'h0});
            chk("contrastTap", {29'h0, biasCtrl.contrastTap},
                {29'h0, refOn ? cst : 3'h0});
            chk("refFromFvr", {31'h0, biasCtrl.refFromFvr}, {31'h0, refOn & fvr});
            rd(ADDR_STATUS, r);
            chk("status", {24'h0, r[7:0]},
                {24'h0, refOn, 3'h0, act, refOn, refOn & fvr, modeB});
        end
        // Ladder timing for both waveform types, codes 1 to 7, with a frozen pause
        for (int w = 0; w < 2; w++) begin
            for (int n = 1; n < 8; n++) begin
                wr(ADDR_CTRL, {30'h0, 1'(w), 1'b1});
                wr(ADDR_REF, 32'h0);
                wr(ADDR_LADDER, {24'h0, 2'h3, 2'h1, 1'b0, 3'(n)});
                settle();
                pulse_start();
                chk("power A", {30'h0, biasCtrl.ladderPower}, 32'h3);
                repeat (n - 1) tick32();
                chk("still A", {31'h0, biasCtrl.ladderModeB}, 32'h0);
                wr(ADDR_CTRL, {30'h0, 1'(w), 1'b0});
                tick32();
                wr(ADDR_CTRL, {30'h0, 1'(w), 1'b1});
                settle();
                chk("frozen", {31'h0, biasCtrl.ladderModeB}, 32'h0);
                tick32();
                chk("to B", {31'h0, biasCtrl.ladderModeB}, 32'h1);
                chk("power B", {30'h0, biasCtrl.ladderPower}, 32'h1);
                tick32();
                tick32();
                chk("B stands", {31'h0, biasCtrl.ladderModeB}, 32'h1);
                pulse_start();
                chk("restart", {31'h0, biasCtrl.ladderModeB}, 32'h0);
            end
        end
        // Reset again with pins in use: all must fall back to plain inputs
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        settle();
        chk("segDriver again", segDriver, 32'h0);
        chk("segOutEn again", segOutEn, 32'h0);
        chk("comOutEn again", {28'h0, comOutEn}, 32'h0);
        rd(ADDR_SEG_DIR, r);
        chk("dir again", r, 32'hFFFFFFFF);
        give_verdict();
    end
endmodule

// file: bench/lcdb_glass_model.sv
// Passive segment LCD glass: reports which electrodes really see a drive
`timescale 1ns/10ps
module lcdb_glass_model #(
    parameter int SEG_PINS = 32
) (
    // Common electrodes
    input wire logic [3:0] comDriver,
    input wire logic [3:0] comOutEn,
    // Segment electrodes
    input wire logic [SEG_PINS-1:0] segDriver,
    input wire logic [SEG_PINS-1:0] segOutEn,
    // Electrodes seen live
    output logic [3:0] liveCom,
    output logic [SEG_PINS-1:0] liveSeg
);
    // A plate only sees a waveform when the pin both drives and is enabled
    assign liveCom = comDriver & comOutEn;
    assign liveSeg = segDriver & segOutEn;
endmodule

// file: src/lcdb_bias_pin_select.sv
// Top of the LCD bias reference control and pin function select block
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module lcdb_bias_pin_select
    import lcdb_pkg::*;
#(
    parameter int SEG_PINS = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    // Timing inputs
    input wire logic clk32kPin,
    input wire logic intervalStart,
    // Bias control outputs
    output lcdb_bias_s biasCtrl,
    // Pin function outputs
    output logic [3:0] comDriver,
    output logic [3:0] comOutEn,
    output logic [SEG_PINS-1:0] segDriver,
    output logic [SEG_PINS-1:0] segOutEn
);

    typedef struct packed {
        logic moduleActiveFlag;
        logic waveformTypeSelect;
        logic [1:0] commonMuxSelect;
        logic [2:0] contrastStepSelect;
        logic [3:0] comDir;
        logic refEnable;
        logic refFromFvr;
        logic ladderIdleBufferOff;
        logic [2:0] externalBiasPin;
        logic [1:0] powerA;
        logic [1:0] powerB;
        logic [2:0] timingCode;
        logic [SEG_PINS-1:0] segmentPinEnable;
        logic [SEG_PINS-1:0] pinDirectionControl;
        logic [2:0] sync;
        lcdb_bias_s bias;
        logic [3:0] comDrv;
        logic [3:0] comOe;
        logic [SEG_PINS-1:0] segDrv;
        logic [SEG_PINS-1:0] segOe;
        logic [DATA_W-1:0] rdata;
    } lcdb_main_s;

    lcdb_main_s st_ff;
    lcdb_main_s nxt_st;
    lcdb_timing_s timing;
    logic tick;
    logic modeB;

    // Commons 0..mux are in use
    function automatic logic [3:0] com_mask(input logic [1:0] mux);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            m[i] = (2'(i) <= mux);
        end
        return m;
    endfunction

    // Driver pins always drive; I/O pins drive when the direction bit is clear
    function automatic logic pin_drive(input logic isDriver, input logic dirIn);
        return isDriver | ~dirIn;
    endfunction

    // Rising edge of the slow clock after two synchroniser stages
    assign tick = st_ff.sync[1] & ~st_ff.sync[2];

    // The timer sees the settings one cycle after their write
    assign timing = '{
        active: st_ff.moduleActiveFlag,
        waveB: st_ff.waveformTypeSelect,
        code: st_ff.timingCode
    };

    lcdb_ladder_timer u_timer (
        .clock(clock),
        .rst_b(rst_b),
        .tick(tick),
        .intervalStart(intervalStart),
        .timing(timing),
        .inModeB(modeB)
    );

    always_comb begin
        logic refOn;
        logic [3:0] cm;
        refOn = 1'b0;
        cm = 4'h0;
        nxt_st = st_ff;
        nxt_st.sync = {st_ff.sync[1:0], clk32kPin};

        // Register writes
        if (regWrite) begin
            if (regAddr == ADDR_CTRL) begin
                nxt_st.moduleActiveFlag = regWdata[CTRL_ACTIVE_BIT];
                nxt_st.waveformTypeSelect = regWdata[CTRL_WAVE_BIT];
                nxt_st.commonMuxSelect = regWdata[CTRL_MUX_LSB +: 2];
                nxt_st.contrastStepSelect = regWdata[CTRL_CST_LSB +: 3];
                nxt_st.comDir = regWdata[CTRL_COMDIR_LSB +: 4];
            end else if (regAddr == ADDR_REF) begin
                nxt_st.refEnable = regWdata[REF_EN_BIT];
                nxt_st.refFromFvr = regWdata[REF_FVR_BIT];
                nxt_st.ladderIdleBufferOff = regWdata[REF_IDLE_BIT];
                nxt_st.externalBiasPin = regWdata[REF_EXT_LSB +: 3];
            end else if (regAddr == ADDR_LADDER) begin
                nxt_st.timingCode = regWdata[LAD_CODE_LSB +: 3];
                nxt_st.powerB = regWdata[LAD_B_LSB +: 2];
                nxt_st.powerA = regWdata[LAD_A_LSB +: 2];
            end else if (regAddr == ADDR_SEG_EN) begin
                nxt_st.segmentPinEnable = regWdata[SEG_PINS-1:0];
            end else if (regAddr == ADDR_SEG_DIR) begin
                nxt_st.pinDirectionControl = regWdata[SEG_PINS-1:0];
            end
        end

        // Register reads, data valid in the following cycle
        nxt_st.rdata = '0;
        if (regRead) begin
            if (regAddr == ADDR_CTRL) begin
                nxt_st.rdata[CTRL_ACTIVE_BIT] = st_ff.moduleActiveFlag;
                nxt_st.rdata[CTRL_WAVE_BIT] = st_ff.waveformTypeSelect;
                nxt_st.rdata[CTRL_MUX_LSB +: 2] = st_ff.commonMuxSelect;
                nxt_st.rdata[CTRL_CST_LSB +: 3] = st_ff.contrastStepSelect;
                nxt_st.rdata[CTRL_COMDIR_LSB +: 4] = st_ff.comDir;
            end else if (regAddr == ADDR_REF) begin
                nxt_st.rdata[REF_EN_BIT] = st_ff.refEnable;
                nxt_st.rdata[REF_FVR_BIT] = st_ff.refFromFvr;
                nxt_st.rdata[REF_IDLE_BIT] = st_ff.ladderIdleBufferOff;
                nxt_st.rdata[REF_EXT_LSB +: 3] = st_ff.externalBiasPin;
            end else if (regAddr == ADDR_LADDER) begin
                nxt_st.rdata[LAD_CODE_LSB +: 3] = st_ff.timingCode;
                nxt_st.rdata[LAD_B_LSB +: 2] = st_ff.powerB;
                nxt_st.rdata[LAD_A_LSB +: 2] = st_ff.powerA;
            end else if (regAddr == ADDR_SEG_EN) begin
                nxt_st.rdata[SEG_PINS-1:0] = st_ff.segmentPinEnable;
            end else if (regAddr == ADDR_SEG_DIR) begin
                nxt_st.rdata[SEG_PINS-1:0] = st_ff.pinDirectionControl;
            end else if (regAddr == ADDR_STATUS) begin
                nxt_st.rdata[STAT_MODEB_BIT] = st_ff.bias.ladderModeB;
                nxt_st.rdata[STAT_FVRREQ_BIT] = st_ff.bias.fvrRequest;
                nxt_st.rdata[STAT_REFON_BIT] = st_ff.bias.refOn;
                nxt_st.rdata[STAT_COM_LSB +: 4] = st_ff.comDrv;
                nxt_st.rdata[STAT_CST_BIT] = st_ff.bias.contrastOn;
            end
        end

        // Bias outputs follow the registered settings one cycle later
        refOn = st_ff.moduleActiveFlag && st_ff.refEnable;
        nxt_st.bias.ladderModeB = modeB;
        if (!st_ff.moduleActiveFlag) begin
            nxt_st.bias.ladderPower = LAD_POWER_OFF;
        end else if (modeB) begin
            nxt_st.bias.ladderPower = st_ff.powerB;
        end else begin
            nxt_st.bias.ladderPower = st_ff.powerA;
        end
        // With no internal reference the contrast ladder has nothing to trim
        nxt_st.bias.contrastOn = refOn;
        nxt_st.bias.contrastTap = refOn ? st_ff.contrastStepSelect : CST_RST;
        nxt_st.bias.refOn = refOn;
        nxt_st.bias.refFromFvr = refOn && st_ff.refFromFvr;
        nxt_st.bias.fvrRequest = refOn && st_ff.refFromFvr;
        nxt_st.bias.fvrBufOn = refOn && st_ff.refFromFvr
            && !(st_ff.ladderIdleBufferOff && modeB);
        // External taps never gate the internal ladder
        nxt_st.bias.extBiasPinEn = st_ff.externalBiasPin;

        // Pin functions; commons are drivers only while the module is active
        cm = st_ff.moduleActiveFlag ? com_mask(st_ff.commonMuxSelect) : 4'h0;
        nxt_st.comDrv = cm;
        for (int i = 0; i < 4; i++) begin
            nxt_st.comOe[i] = pin_drive(cm[i], st_ff.comDir[i]);
        end
        nxt_st.segDrv = st_ff.segmentPinEnable;
        for (int i = 0; i < SEG_PINS; i++) begin
            nxt_st.segOe[i] = pin_drive(st_ff.segmentPinEnable[i],
                st_ff.pinDirectionControl[i]);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
            st_ff.comDir <= COMDIR_RST;
            st_ff.externalBiasPin <= EXT_RST;
            st_ff.powerA <= LAD_POWER_RST;
            st_ff.powerB <= LAD_POWER_RST;
            st_ff.timingCode <= LAD_CODE_RST;
            st_ff.commonMuxSelect <= MUX_RST;
            st_ff.contrastStepSelect <= CST_RST;
            st_ff.segmentPinEnable <= {SEG_PINS{SEG_EN_RST}};
            st_ff.pinDirectionControl <= {SEG_PINS{SEG_DIR_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign regRdata = st_ff.rdata;
    assign biasCtrl = st_ff.bias;
    assign comDriver = st_ff.comDrv;
    assign comOutEn = st_ff.comOe;
    assign segDriver = st_ff.segDrv;
    assign segOutEn = st_ff.segOe;

    a_contrast_off_idle: assert property (@(posedge clock) disable iff (!rst_b)
        !st_ff.moduleActiveFlag |=> !biasCtrl.contrastOn && biasCtrl.contrastTap == CST_RST)
        else $error("contrast ladder on while inactive");

    a_contrast_tap: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.moduleActiveFlag && st_ff.refEnable
            |=> biasCtrl.contrastTap == $past(st_ff.contrastStepSelect))
        else $error("contrast tap does not follow step select");

    a_ref_off_idle: assert property (@(posedge clock) disable iff (!rst_b)
        !st_ff.moduleActiveFlag |=> !biasCtrl.refOn && !biasCtrl.fvrRequest)
        else $error("internal reference on while inactive");

    a_fvr_auto: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.moduleActiveFlag && st_ff.refEnable && st_ff.refFromFvr |=> biasCtrl.fvrRequest)
        else $error("fixed reference not requested");

    a_buffer_idle_b: assert property (@(posedge clock) disable iff (!rst_b)
        biasCtrl.ladderModeB && $past(st_ff.ladderIdleBufferOff) |-> !biasCtrl.fvrBufOn)
        else $error("reference buffer on in mode B with idle bit set");

    a_power_select: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.moduleActiveFlag && modeB |=> biasCtrl.ladderPower == $past(st_ff.powerB))
        else $error("ladder power not mode B level");

    a_com_mask: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.moduleActiveFlag && st_ff.commonMuxSelect == 2'h1 |=> comDriver == 4'h3)
        else $error("common pins wrong for two-way mux");

    a_seg_override: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.segmentPinEnable[0] |=> segDriver[0] && segOutEn[0])
        else $error("segment enable did not override direction");

    a_com_dir: assert property (@(posedge clock) disable iff (!rst_b)
        !st_ff.moduleActiveFlag |=> comOutEn == ~$past(st_ff.comDir))
        else $error("I/O common pin ignores direction bit");

    a_ref_on_active: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.moduleActiveFlag && st_ff.refEnable |=> biasCtrl.contrastOn && biasCtrl.refOn)
        else $error("internal reference not on while enabled");

    a_no_ref_trim: assert property (@(posedge clock) disable iff (!rst_b)
        !st_ff.refEnable |=> !biasCtrl.contrastOn && !biasCtrl.refFromFvr)
        else $error("contrast or source on without internal reference");

    a_tap_no_ref: assert property (@(posedge clock) disable iff (!rst_b)
        !st_ff.refEnable |=> biasCtrl.contrastTap == CST_RST)
        else $error("contrast tap set without internal reference");

    a_power_off_idle: assert property (@(posedge clock) disable iff (!rst_b)
        !st_ff.moduleActiveFlag |=> biasCtrl.ladderPower == LAD_POWER_OFF)
        else $error("ladder powered while inactive");

    a_power_mode_a: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.moduleActiveFlag && !modeB |=> biasCtrl.ladderPower == $past(st_ff.powerA))
        else $error("ladder power not mode A level");

    a_buffer_on_a: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.moduleActiveFlag && st_ff.refEnable && st_ff.refFromFvr && !modeB
            |=> biasCtrl.fvrBufOn)
        else $error("reference buffer off in mode A");

    a_fvr_unneeded: assert property (@(posedge clock) disable iff (!rst_b)
        !st_ff.refFromFvr |=> !biasCtrl.fvrRequest && !biasCtrl.fvrBufOn)
        else $error("fixed reference requested without need");

    a_ext_keeps_ladder: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.moduleActiveFlag && st_ff.externalBiasPin != 3'h0 && !modeB
            |=> biasCtrl.ladderPower == $past(st_ff.powerA))
        else $error("external bias pins stopped the ladder");

    a_com_static: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.moduleActiveFlag && st_ff.commonMuxSelect == 2'h0 |=> comDriver == 4'h1)
        else $error("common pins wrong for static drive");

    a_com_full_dir: assert property (@(posedge clock) disable iff (!rst_b)
        st_ff.moduleActiveFlag && st_ff.commonMuxSelect == 2'h3 |=> comOutEn == 4'hF)
        else $error("common driver obeyed direction bit");

    a_seg_io_dir: assert property (@(posedge clock) disable iff (!rst_b)
        !st_ff.segmentPinEnable[0]
            |=> !segDriver[0] && segOutEn[0] == !$past(st_ff.pinDirectionControl[0]))
        else $error("I/O segment pin ignores direction bit");

endmodule

// file: src/lcdb_ladder_timer.sv
// Mode A / mode B timing of the reference ladder within one waveform interval
`timescale 1ns/10ps
module lcdb_ladder_timer
    import lcdb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Timing control
    input wire logic tick,
    input wire logic intervalStart,
    input wire lcdb_timing_s timing,
    // Result
    output logic inModeB
);

    typedef struct packed {
        logic [2:0] cnt;
        logic modeB;
    } lcdb_timer_s;

    lcdb_timer_s st_ff;
    lcdb_timer_s nxt_st;

    // Waveform type only changes the interval length; mode A length is the code either way
    always_comb begin
        nxt_st = st_ff;
        if (intervalStart) begin
            nxt_st.cnt = 3'h0;
            nxt_st.modeB = (timing.code == 3'h0);
        end else if (timing.active && tick && !st_ff.modeB) begin
            nxt_st.cnt = 3'(st_ff.cnt + 3'h1);
            if (3'(st_ff.cnt + 3'h1) == timing.code) begin
                nxt_st.modeB = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign inModeB = st_ff.modeB;

    a_start_mode_a: assert property (@(posedge clock) disable iff (!rst_b)
        intervalStart && timing.code != 3'h0 |=> !inModeB && st_ff.cnt == 3'h0)
        else $error("interval start did not restart mode A");

    a_n_clocks_a: assert property (@(posedge clock) disable iff (!rst_b)
        !intervalStart && timing.active && tick && !st_ff.modeB
            && st_ff.cnt == 3'(timing.code - 3'h1) |=> inModeB)
        else $error("mode B not entered after n clocks");

    a_b_holds: assert property (@(posedge clock) disable iff (!rst_b)
        inModeB && !intervalStart |=> inModeB)
        else $error("mode B left before interval end");

    a_idle_frozen: assert property (@(posedge clock) disable iff (!rst_b)
        !timing.active && !intervalStart |=> $stable(st_ff.cnt))
        else $error("timer counted while module inactive");

endmodule

// file: src/lcdb_pkg.sv
// Constants and carrier types of the LCD bias and pin select block
package lcdb_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_REF = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_LADDER = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_SEG_EN = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_SEG_DIR = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;

    // Control word fields
    localparam int CTRL_ACTIVE_BIT = 0;
    localparam int CTRL_WAVE_BIT = 1;
    localparam int CTRL_MUX_LSB = 2;
    localparam int CTRL_CST_LSB = 4;
    localparam int CTRL_COMDIR_LSB = 8;

    // Reference word fields
    localparam int REF_EN_BIT = 0;
    localparam int REF_FVR_BIT = 1;
    localparam int REF_IDLE_BIT = 2;
    localparam int REF_EXT_LSB = 3;

    // Ladder word fields
    localparam int LAD_CODE_LSB = 0;
    localparam int LAD_B_LSB = 4;
    localparam int LAD_A_LSB = 6;

    // Status word fields
    localparam int STAT_MODEB_BIT = 0;
    localparam int STAT_FVRREQ_BIT = 1;
    localparam int STAT_REFON_BIT = 2;
    localparam int STAT_COM_LSB = 3;
    localparam int STAT_CST_BIT = 7;

    // Reset values
    localparam logic [3:0] COMDIR_RST = 4'hF;
    localparam logic [2:0] EXT_RST = 3'h0;
    localparam logic [1:0] LAD_POWER_RST = 2'h0;
    localparam logic [2:0] LAD_CODE_RST = 3'h0;
    localparam logic [1:0] MUX_RST = 2'h0;
    localparam logic [2:0] CST_RST = 3'h0;
    localparam logic SEG_EN_RST = 1'b0;
    localparam logic SEG_DIR_RST = 1'b1;

    // Ladder power level meaning "off"
    localparam logic [1:0] LAD_POWER_OFF = 2'h0;

    typedef struct packed {
        logic [1:0] ladderPower;
        logic ladderModeB;
        logic contrastOn;
        logic [2:0] contrastTap;
        logic refOn;
        logic refFromFvr;
        logic fvrBufOn;
        logic fvrRequest;
        logic [2:0] extBiasPinEn;
    } lcdb_bias_s;

    typedef struct packed {
        logic active;
        logic waveB;
        logic [2:0] code;
    } lcdb_timing_s;

endpackage
